// *** core/wdrc_defines.vh ***
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH

// Register word indices; byte address is four times the index
`define WDRC_OFS_DOG_CTRL     6'h00
`define WDRC_OFS_CAUSE        6'h01
`define WDRC_OFS_UV_CTRL      6'h02
`define WDRC_OFS_STATUS       6'h03

// Power-on values
`define WDRC_DOG_CTRL_POR     8'h53
`define WDRC_UV_CTRL_POR      8'h5A
`define WDRC_PORT_POR         8'hFF

// Key patterns
`define WDRC_DOG_KEY_A        5'h0A
`define WDRC_DOG_KEY_B        5'h15
`define WDRC_UV_KEY_ON        8'h5A
`define WDRC_UV_KEY_OFF       8'hA5

// Field positions
`define WDRC_KEY_HI           7
`define WDRC_KEY_LO           3
`define WDRC_SEL_HI           2
`define WDRC_SEL_LO           0
`define WDRC_CAUSE_DOG_KEY    0
`define WDRC_CAUSE_UV_KEY     1
`define WDRC_CAUSE_UV_EVENT   2
`define WDRC_STAT_EXPIRY      0
`define WDRC_STAT_SLEEP       1

// Timing counts in slow oscillator periods
`define WDRC_SOFT_RESET_DELAY 16'd32
`define WDRC_UV_FILTER_TIME   16'd4

// AXI responses
`define WDRC_RESP_OKAY        2'b00
`define WDRC_RESP_SLVERR      2'b10

`endif

// *** core/wdrc_slow_count.v ***
`default_nettype none

// Counts slow ticks while run is high; pulses done on the next tick after the count reaches limit
module wdrc_slow_count (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// Control
	input  wire        run,
	input  wire        tick,
	input  wire [15:0] limit,
	// Result
	output reg         done
);

	reg [15:0] count_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= 16'h0000;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!run) begin
				count_reg <= 16'h0000;
			end else if (tick) begin
				if (count_reg == limit) begin
					// Restart so a lingering run cannot fire twice at once
					count_reg <= 16'h0000;
					done      <= 1'b1;
				end else begin
					count_reg <= count_reg + 16'h0001;
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** core/wdrc_top.v ***
`include "wdrc_defines.vh"
`default_nettype none

module wdrc_top #(
	parameter [15:0] SOFT_RESET_DELAY = `WDRC_SOFT_RESET_DELAY,
	parameter [15:0] UV_FILTER_TIME   = `WDRC_UV_FILTER_TIME
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address and data
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Pins
	input  wire        slow_internal_osc,
	input  wire        low_supply,
	// Core events
	input  wire        clear_dog_instr,
	input  wire        halt_instr,
	input  wire        sleep_idle,
	// Reset actions
	output reg         cpu_full_reset,
	output reg         pc_sp_clear,
	output reg  [7:0]  port_data_init,
	output reg  [7:0]  port_dir_init,
	output reg         dog_enabled,
	output reg         undervolt_armed
);

	// Synchronisers and slow tick
	reg        osc_meta_reg;
	reg        osc_sync_reg;
	reg        osc_prev_reg;
	reg        low_meta_reg;
	reg        low_sync_reg;
	wire       slow_tick;

	// Registers and state
	reg [7:0]  dog_control_reg;
	reg [7:0]  undervolt_control_reg;
	reg [2:0]  reset_cause_reg;
	reg        expiry_flag_reg;
	reg        sleep_entered_flag_reg;
	reg [18:0] dog_count_reg;

	// AXI slave state
	reg        aw_held_reg;
	reg        w_held_reg;
	reg [5:0]  aw_index_reg;
	reg [7:0]  w_byte_reg;
	reg        w_lane0_reg;

	wire       aw_take;
	wire       w_take;
	wire       wr_do;
	wire       ar_take;
	wire [5:0] ar_index;
	wire       wr_dog;
	wire       wr_cause;
	wire       wr_uv;
	wire       wr_ok;

	wire [4:0] dog_key;
	wire       dog_key_legal;
	wire       uv_key_legal;
	wire       uv_on;
	wire       dog_limit_hit;
	wire       dog_overflow;
	wire       ovf_normal;
	wire       ovf_sleep;
	wire       dog_key_done;
	wire       uv_key_done;
	wire       uv_filter_done;
	wire       full_reset;
	wire       uv_reload;
	reg [18:0] dog_limit;
	reg [2:0]  cause_next;

	// Pins cross into aclk through two flops
	always @(posedge aclk) begin
		if (!aresetn) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			low_meta_reg <= 1'b0;
			low_sync_reg <= 1'b0;
		end else begin
			osc_meta_reg <= slow_internal_osc;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
			low_meta_reg <= low_supply;
			low_sync_reg <= low_meta_reg;
		end
	end

	assign slow_tick = osc_sync_reg & ~osc_prev_reg;

	assign dog_key       = dog_control_reg[`WDRC_KEY_HI:`WDRC_KEY_LO];
	assign dog_key_legal = (dog_key == `WDRC_DOG_KEY_A) || (dog_key == `WDRC_DOG_KEY_B);
	assign uv_key_legal  = (undervolt_control_reg == `WDRC_UV_KEY_ON) ||
	                       (undervolt_control_reg == `WDRC_UV_KEY_OFF);
	assign uv_on         = (undervolt_control_reg == `WDRC_UV_KEY_ON) && !sleep_idle;

	always @* begin
		case (dog_control_reg[`WDRC_SEL_HI:`WDRC_SEL_LO])
			3'h0: dog_limit = 19'h000FF;
			3'h1: dog_limit = 19'h003FF;
			3'h2: dog_limit = 19'h00FFF;
			3'h3: dog_limit = 19'h03FFF;
			3'h4: dog_limit = 19'h07FFF;
			3'h5: dog_limit = 19'h0FFFF;
			3'h6: dog_limit = 19'h1FFFF;
			default: dog_limit = 19'h3FFFF;
		endcase
	end

	// Shortening the select never skips overflow: compare is at-or-above
	assign dog_limit_hit = dog_count_reg >= dog_limit;
	assign dog_overflow  = dog_key_legal && slow_tick && dog_limit_hit;
	assign ovf_normal    = dog_overflow && !sleep_idle;
	assign ovf_sleep     = dog_overflow && sleep_idle;

	wdrc_slow_count u_dog_key_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (!dog_key_legal),
		.tick    (slow_tick),
		.limit   (SOFT_RESET_DELAY),
		.done    (dog_key_done)
	);

	wdrc_slow_count u_uv_key_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (!uv_key_legal),
		.tick    (slow_tick),
		.limit   (SOFT_RESET_DELAY),
		.done    (uv_key_done)
	);

	wdrc_slow_count u_uv_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (uv_on && low_sync_reg),
		.tick    (slow_tick),
		.limit   (UV_FILTER_TIME),
		.done    (uv_filter_done)
	);

	assign full_reset = ovf_normal || dog_key_done || uv_key_done || uv_filter_done;
	assign uv_reload  = ovf_normal || dog_key_done || uv_key_done;

	// AXI handshakes
	assign aw_take  = s_axi_awvalid && s_axi_awready;
	assign w_take   = s_axi_wvalid && s_axi_wready;
	assign wr_do    = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign ar_take  = s_axi_arvalid && s_axi_arready;
	assign ar_index = s_axi_araddr[7:2];
	assign wr_ok    = wr_do && w_lane0_reg;
	assign wr_dog   = wr_ok && (aw_index_reg == `WDRC_OFS_DOG_CTRL);
	assign wr_cause = wr_ok && (aw_index_reg == `WDRC_OFS_CAUSE);
	assign wr_uv    = wr_ok && (aw_index_reg == `WDRC_OFS_UV_CTRL);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_index_reg  <= 6'h00;
			w_byte_reg    <= 8'h00;
			w_lane0_reg   <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `WDRC_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_reg  <= 1'b1;
				aw_index_reg <= s_axi_awaddr[7:2];
			end else if (wr_do) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg  <= 1'b1;
				w_byte_reg  <= s_axi_wdata[7:0];
				w_lane0_reg <= s_axi_wstrb[0];
			end else if (wr_do) begin
				w_held_reg <= 1'b0;
			end
			// Each channel reopens once its word is consumed
			s_axi_awready <= !(aw_take || (aw_held_reg && !wr_do));
			s_axi_wready  <= !(w_take || (w_held_reg && !wr_do));
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_index_reg <= `WDRC_OFS_STATUS) ? `WDRC_RESP_OKAY : `WDRC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `WDRC_RESP_OKAY;
		end else begin
			s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `WDRC_RESP_OKAY;
				case (ar_index)
					`WDRC_OFS_DOG_CTRL: s_axi_rdata <= {24'h000000, dog_control_reg};
					`WDRC_OFS_CAUSE:    s_axi_rdata <= {29'h00000000, reset_cause_reg};
					`WDRC_OFS_UV_CTRL:  s_axi_rdata <= {24'h000000, undervolt_control_reg};
					`WDRC_OFS_STATUS:   s_axi_rdata <= {30'h00000000, sleep_entered_flag_reg, expiry_flag_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `WDRC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Cause flags: written zeros clear, hardware sets win
	always @* begin
		cause_next = reset_cause_reg;
		if (wr_cause) begin
			cause_next = reset_cause_reg & w_byte_reg[2:0];
		end
		if (!dog_key_legal) begin
			cause_next[`WDRC_CAUSE_DOG_KEY] = 1'b1;
		end
		if (!uv_key_legal) begin
			cause_next[`WDRC_CAUSE_UV_KEY] = 1'b1;
		end
		if (uv_filter_done) begin
			cause_next[`WDRC_CAUSE_UV_EVENT] = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			dog_control_reg        <= `WDRC_DOG_CTRL_POR;
			undervolt_control_reg  <= `WDRC_UV_CTRL_POR;
			reset_cause_reg        <= 3'h0;
			expiry_flag_reg        <= 1'b0;
			sleep_entered_flag_reg <= 1'b0;
			dog_count_reg          <= 19'h00000;
		end else begin
			reset_cause_reg <= cause_next;
			if (full_reset) begin
				dog_control_reg <= `WDRC_DOG_CTRL_POR;
			end else if (wr_dog) begin
				dog_control_reg <= w_byte_reg;
			end
			if (uv_reload) begin
				undervolt_control_reg <= `WDRC_UV_CTRL_POR;
			end else if (wr_uv) begin
				undervolt_control_reg <= w_byte_reg;
			end
			if (!dog_key_legal || clear_dog_instr || halt_instr || full_reset || dog_overflow) begin
				dog_count_reg <= 19'h00000;
			end else if (slow_tick) begin
				dog_count_reg <= dog_count_reg + 19'h00001;
			end
			if (dog_overflow) begin
				expiry_flag_reg <= 1'b1;
			end else if (clear_dog_instr || halt_instr) begin
				expiry_flag_reg <= 1'b0;
			end
			if (halt_instr) begin
				sleep_entered_flag_reg <= 1'b1;
			end else if (clear_dog_instr) begin
				sleep_entered_flag_reg <= 1'b0;
			end
		end
	end

	// Reset action outputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			cpu_full_reset  <= 1'b1;
			pc_sp_clear     <= 1'b1;
			port_data_init  <= `WDRC_PORT_POR;
			port_dir_init   <= `WDRC_PORT_POR;
			dog_enabled     <= 1'b0;
			undervolt_armed <= 1'b0;
		end else begin
			cpu_full_reset  <= full_reset;
			pc_sp_clear     <= full_reset || ovf_sleep;
			port_data_init  <= `WDRC_PORT_POR;
			port_dir_init   <= `WDRC_PORT_POR;
			dog_enabled     <= dog_key_legal;
			undervolt_armed <= uv_on;
		end
	end

endmodule

`default_nettype wire

// *** testbench/wdrc_top_sva.sv ***
`default_nettype none
module wdrc_top_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Core side
	input wire logic        sleep_idle,
	input wire logic        cpu_full_reset,
	input wire logic        pc_sp_clear,
	input wire logic [7:0]  port_data_init,
	input wire logic [7:0]  port_dir_init,
	input wire logic        dog_enabled,
	input wire logic        undervolt_armed
);
	timeunit 1ns;
	timeprecision 1ps;

	reset_pulse_a: assert property (@(posedge aclk) !aresetn |=> cpu_full_reset && pc_sp_clear)
		else $error("reset pulses missing");
	pulse_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && cpu_full_reset |=> !cpu_full_reset) else $error("full reset longer than one cycle");
	full_pcsp_a: assert property (@(posedge aclk) cpu_full_reset |-> pc_sp_clear)
		else $error("full reset without pc clear");
	port_init_a: assert property (@(posedge aclk) disable iff (!aresetn)
		port_data_init == 8'hFF && port_dir_init == 8'hFF) else $error("port init not all ones");
	sleep_uv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep_idle |=> !undervolt_armed) else $error("undervoltage armed while sleeping");
	dog_por_a: assert property (@(posedge aclk) $rose(aresetn) |=> dog_enabled)
		else $error("watchdog not enabled after power-on");
	wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
	r_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
`default_nettype wire

// *** testbench/tb_watchdog_and_reset_control.sv ***
`default_nettype none
module tb_watchdog_and_reset_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 0, aresetn = 0, low_supply = 0, sleep_idle = 0;
	logic        clear_dog_instr = 0, halt_instr = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [2:0]  osc_div = 0;
	wire         slow_internal_osc, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         cpu_full_reset, pc_sp_clear, dog_enabled, undervolt_armed;
	wire  [7:0]  port_data_init, port_dir_init;
	int          bad_count = 0, n_checks = 0, n;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic        fr, ps;

	wdrc_top #(.SOFT_RESET_DELAY(16'd2), .UV_FILTER_TIME(16'd1)) uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .slow_internal_osc(slow_internal_osc), .low_supply(low_supply),
		.clear_dog_instr(clear_dog_instr), .halt_instr(halt_instr), .sleep_idle(sleep_idle),
		.cpu_full_reset(cpu_full_reset), .pc_sp_clear(pc_sp_clear), .port_data_init(port_data_init),
		.port_dir_init(port_dir_init), .dog_enabled(dog_enabled), .undervolt_armed(undervolt_armed));

	always #2 aclk = ~aclk;
	// Slow oscillator at one eighth of the bus clock keeps long timeouts cheap
	always @(posedge aclk) osc_div <= osc_div + 3'h1;
	assign slow_internal_osc = osc_div[2];

	task automatic stop_test;
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang(input string nm);
		$display("FAIL %s exp 1 got 0", nm);
		bad_count++;
		stop_test;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("FAIL %s exp %h got %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (1) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_bvalid)
				break;
			k++;
			if (k > 50)
				hang("bvalid");
		end
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (1) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 0;
			if (s_axi_rvalid)
				break;
			k++;
			if (k > 50)
				hang("rvalid");
		end
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		chk(nm, e, rd);
	endtask
	task automatic pulse(input bit h);
		@(posedge aclk);
		if (h)
			halt_instr <= 1;
		else
			clear_dog_instr <= 1;
		@(posedge aclk);
		halt_instr <= 0;
		clear_dog_instr <= 0;
	endtask
	// Stops at the first reset pulse; must marks a pulse that has to come
	task automatic wait_rst(input int lim, input bit must);
		n = 0;
		fr = 0;
		ps = 0;
		while (!(fr || ps) && n < lim) begin
			@(posedge aclk);
			fr = cpu_full_reset;
			ps = pc_sp_clear;
			n++;
		end
		if (must && !(fr || ps))
			hang("reset_pulse");
	endtask
	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
	endtask

	task automatic s_por;
		rdc("por_dog", 8'h00, 32'h53);
		chk("rd_resp", 32'h0, {30'h0, rs});
		rdc("por_cause", 8'h04, 32'h0);
		rdc("por_uv", 8'h08, 32'h5A);
		rdc("por_stat", 8'h0C, 32'h0);
		rdc("unmapped", 8'h10, 32'h0);
		chk("unmapped_resp", 32'h2, {30'h0, rs});
		axi_wr(8'h0C, 32'h3);
		chk("wr_resp", 32'h0, {30'h0, rs});
		rdc("stat_ro", 8'h0C, 32'h0);
		chkb("dog_on", 1, dog_enabled);
		axi_wr(8'h00, 32'h54);
		wait_rst(40, 0);
		chkb("sel_norst", 0, fr);
	endtask
	task automatic s_timeout(input logic [2:0] code, input int ticks);
		axi_wr(8'h00, {24'h0, 5'h0A, code});
		pulse(0);
		wait_rst((ticks + 2) * 8 + 40, 1);
		chkb("ovf_full", 1, fr);
		chkb("ovf_early", 1, n >= (ticks - 1) * 8);
		chkb("ovf_late", 1, n <= (ticks + 1) * 8 + 8);
		rdc("ovf_expiry", 8'h0C, 32'h1);
		rdc("ovf_reload", 8'h00, 32'h53);
	endtask
	task automatic s_sleep;
		pulse(1);
		rdc("halt_flags", 8'h0C, 32'h2);
		sleep_idle <= 1;
		axi_wr(8'h00, 32'h50);
		pulse(1);
		wait_rst(256 * 8 + 80, 1);
		chkb("sleep_full", 0, fr);
		chkb("sleep_pcsp", 1, ps);
		rdc("sleep_flags", 8'h0C, 32'h3);
		rdc("sleep_kept", 8'h00, 32'h50);
		sleep_idle <= 0;
		pulse(0);
		rdc("clr_flags", 8'h0C, 32'h0);
	endtask
	task automatic s_dog_key;
		axi_wr(8'h00, 32'h0);
		wait_rst(80, 1);
		chkb("key_full", 1, fr);
		chkb("key_delay", 1, n >= 16);
		rdc("key_fault", 8'h04, 32'h1);
		rdc("key_reload", 8'h00, 32'h53);
		axi_wr(8'h04, 32'hFF);
		rdc("fault_keep", 8'h04, 32'h1);
		axi_wr(8'h04, 32'h0);
		rdc("fault_clr", 8'h04, 32'h0);
	endtask
	task automatic s_uv_key;
		axi_wr(8'h08, 32'h33);
		wait_rst(80, 1);
		chkb("uvk_full", 1, fr);
		rdc("uvk_reload", 8'h08, 32'h5A);
		rdc("uvk_fault", 8'h04, 32'h2);
		axi_wr(8'h04, 32'h0);
		rdc("uvk_clr", 8'h04, 32'h0);
	endtask
	task automatic s_uv;
		axi_wr(8'h08, 32'hA5);
		low_supply <= 1;
		wait_rst(60, 0);
		chkb("uv_off", 0, fr);
		chkb("uv_unarmed", 0, undervolt_armed);
		low_supply <= 0;
		axi_wr(8'h08, 32'h5A);
		// Four cycles span at most one slow tick, short of the filter
		low_supply <= 1;
		repeat (4) @(posedge aclk);
		low_supply <= 0;
		wait_rst(60, 0);
		chkb("uv_glitch", 0, fr);
		chkb("uv_armed", 1, undervolt_armed);
		low_supply <= 1;
		wait_rst(80, 1);
		low_supply <= 0;
		chkb("uv_full", 1, fr);
		rdc("uv_flag", 8'h04, 32'h4);
		rdc("uv_kept", 8'h08, 32'h5A);
		axi_wr(8'h04, 32'h0);
		rdc("uv_clr", 8'h04, 32'h0);
	endtask

	initial begin
		do_reset;
		s_por;
		do_reset;
		s_timeout(3'h0, 256);
		do_reset;
		s_timeout(3'h1, 1024);
		do_reset;
		s_sleep;
		do_reset;
		s_dog_key;
		do_reset;
		s_uv_key;
		do_reset;
		s_uv;
		stop_test;
	end
endmodule

bind wdrc_top wdrc_top_chk chk_i (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .sleep_idle(sleep_idle), .cpu_full_reset(cpu_full_reset),
	.pc_sp_clear(pc_sp_clear), .port_data_init(port_data_init), .port_dir_init(port_dir_init),
	.dog_enabled(dog_enabled), .undervolt_armed(undervolt_armed));
`default_nettype wire
